// ### src/pwm_event_pkg.sv
// Purpose: constants and types for the timer event, flag and status block
// Assumes: word-indexed Avalon-MM register map, byte address is four times the index
// Notes:   one clock; timer-domain crossing modelled by a fixed sync latency
// What this block does
// - config field selects none, filter, async
// - filter changes after four agreeing samples
// - filtered capture lags three extra cycles
// - async mode bypasses the sampling synchroniser
// - edge bit picks falling/low or rising/high
// - action bit: fault only, or fault plus capture
// - trigger enable A gates event A
// - trigger enable B gates event B
// - enables for trigger B bit3, A bit2
// - enable bit0 gates cycle-end interrupt
// - trigger or capture B sets flag bit3
// - trigger or capture A sets flag bit2
// - cycle end sets flag bit0
// - flags clear on writing one
// - output B toggle sets status bit7
// - output A toggle sets status bit6
// - activity bits sticky until written one
// - command ready bit1 when command synced
// - listed strobes drop command ready
// - enable ready bit0 when enable synced
// - enable write, disable strobe, break with debug run off drop ready
// - command strobes ignored while command synchronising; disable strobe still taken
// - enable changes only when not synchronising
package pwm_event_pkg;
    localparam logic [4:0] CONTROL_REG_A_IDX      = 5'h00;
    localparam logic [4:0] CONTROL_REG_C_IDX      = 5'h02;
    localparam logic [4:0] COMMAND_STROBE_REG_IDX = 5'h04;
    localparam logic [4:0] EVENT_INPUT_A_CTRL_IDX = 5'h08;
    localparam logic [4:0] EVENT_INPUT_B_CTRL_IDX = 5'h09;
    localparam logic [4:0] INTERRUPT_ENABLE_IDX   = 5'h0c;
    localparam logic [4:0] INTERRUPT_FLAG_IDX     = 5'h0d;
    localparam logic [4:0] SYNC_STATUS_IDX        = 5'h0e;
    localparam logic [4:0] DEBUG_RUN_CONTROL_IDX  = 5'h1e;
    localparam logic [4:0] COMPARE_B_CLEAR_HI_IDX = 5'h1f;
    // Event control fields
    localparam int CFG_HI = 7;
    localparam int CFG_LO = 6;
    localparam int EDGE_BIT = 4;
    localparam int ACTION_BIT = 2;
    localparam int TRIG_EN_BIT = 0;
    localparam logic [1:0] CFG_NEITHER = 2'h0;
    localparam logic [1:0] CFG_FILTER  = 2'h1;
    localparam logic [1:0] CFG_ASYNC   = 2'h2;
    // Flag, enable and status bits
    localparam int TRIG_B_BIT = 3;
    localparam int TRIG_A_BIT = 2;
    localparam int CYCLE_END_BIT = 0;
    localparam logic [7:0] FLAG_MASK = 8'h0d;
    localparam int ACT_B_BIT = 7;
    localparam int ACT_A_BIT = 6;
    localparam int CMD_READY_BIT = 1;
    localparam int EN_READY_BIT = 0;
    // Control and strobe bits
    localparam int ENABLE_BIT = 0;
    localparam int AUTO_UPDATE_BIT = 1;
    localparam int DEBUG_RUN_BIT = 0;
    localparam int DISABLE_EOC_BIT = 7;
    localparam logic [7:0] CMD_STROBE_MASK = 8'h1f;
    localparam logic [7:0] CYCLE_END_LOAD_CMD = 8'h01;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int FILTER_SAMPLES = 4;
    localparam int SYNC_LATENCY = 4;
    typedef enum logic [2:0] {
        EN_IDLE     = 3'b001,
        EN_SYNC     = 3'b010,
        EN_WAIT_EOC = 3'b100
    } enable_state_t;
endpackage : pwm_event_pkg

// ### src/pwm_timer_event_irq_status.sv
// Purpose: event conditioning, interrupt flags and sync status of the PWM timer
// Assumes: Avalon-MM slave, word address = register index, one wait state
// Notes:   all outputs registered; async event path skips only the synchroniser
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
module pwm_timer_event_irq_status
    import pwm_event_pkg::*;
#(
    parameter int SYNC_CYCLES = pwm_event_pkg::SYNC_LATENCY,
    parameter int FILTER_LEN  = pwm_event_pkg::FILTER_SAMPLES
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [4:0] address,
    input  wire logic       read,
    input  wire logic       write,
    input  wire logic [31:0] writedata,
    output logic [31:0]     readdata,
    output logic            waitrequest,
    input  wire logic       eventA,
    input  wire logic       eventB,
    input  wire logic       waveformOutputA,
    input  wire logic       waveformOutputB,
    input  wire logic       cycleEnd,
    input  wire logic       debugBreak,
    output logic            faultA,
    output logic            faultB,
    output logic            captureA,
    output logic            captureB,
    output logic [4:0]      commandIssue,
    output logic            timerEnable,
    output logic            irq
);
    import pwm_event_pkg::*;

    localparam logic [3:0] SYNC_LOAD = 4'(SYNC_CYCLES);
    localparam logic [2:0] FILT_TOP  = 3'(FILTER_LEN - 1);

    typedef struct packed {
        logic [31:0]   readdata;
        logic          waitrequest;
        logic [7:0]    event_input_a_control;
        logic [7:0]    event_input_b_control;
        logic [7:0]    intEnable;
        logic [7:0]    intFlag;
        logic [1:0]    activity;
        logic          enable;
        logic          autoUpdate;
        logic          debugRun;
        logic [1:0]    sampleA;
        logic [1:0]    sampleB;
        logic          condA;
        logic          condB;
        logic [2:0]    filtCountA;
        logic [2:0]    filtCountB;
        logic          activeA;
        logic          activeB;
        logic [1:0]    waveformPrev;
        logic          breakPrev;
        logic [3:0]    cmdCount;
        logic [4:0]    cmdPending;
        logic [3:0]    enCount;
        logic          enTarget;
        enable_state_t enState;
        logic          faultA;
        logic          faultB;
        logic          captureA;
        logic          captureB;
        logic [4:0]    commandIssue;
        logic          timerEnable;
        logic          irq;
    } state_t;

    state_t q;
    state_t next_q;

    // Raw sampled source for one event input by mode
    function automatic logic pickSource(input logic [1:0] cfg, input logic raw,
                                        input logic synced);
        pickSource = (cfg == CFG_ASYNC) ? raw : synced;
    endfunction : pickSource

    // Active condition for the chosen polarity
    function automatic logic isActive(input logic [7:0] ctrl, input logic level);
        isActive = ctrl[EDGE_BIT] ? level : ~level;
    endfunction : isActive

    // Register read mux
    function automatic logic [7:0] readReg(input logic [4:0] idx, input state_t s);
        case (idx)
            CONTROL_REG_A_IDX:      readReg = {7'h00, s.enable};
            CONTROL_REG_C_IDX:      readReg = {6'h00, s.autoUpdate, 1'b0};
            EVENT_INPUT_A_CTRL_IDX: readReg = s.event_input_a_control;
            EVENT_INPUT_B_CTRL_IDX: readReg = s.event_input_b_control;
            INTERRUPT_ENABLE_IDX:   readReg = s.intEnable;
            INTERRUPT_FLAG_IDX:     readReg = s.intFlag;
            SYNC_STATUS_IDX:        readReg = {s.activity, 4'h0,
                                               s.cmdCount == 4'h0,
                                               s.enState == EN_IDLE};
            DEBUG_RUN_CONTROL_IDX:  readReg = {7'h00, s.debugRun};
            default:                readReg = 8'h00;
        endcase
    endfunction : readReg

    // Filter step: output moves after FILTER_LEN agreeing samples
    function automatic logic [3:0] filterStep(input logic [1:0] cfg, input logic src,
                                              input logic cond, input logic [2:0] cnt);
        logic [2:0] c;
        logic       o;
        c = cnt;
        o = cond;
        if (cfg != CFG_FILTER) begin
            o = src;
            c = 3'h0;
        end else if (src == cond) begin
            c = 3'h0;
        end else if (cnt == FILT_TOP) begin
            o = src;
            c = 3'h0;
        end else begin
            c = cnt + 3'h1;
        end
        filterStep = {o, c};
    endfunction : filterStep

    // Next-state logic
    always_comb begin
        logic       acc;
        logic       wrOk;
        logic [7:0] wd;
        logic       srcA;
        logic       srcB;
        logic       actA;
        logic       actB;
        logic       edgeA;
        logic       edgeB;
        logic       capA;
        logic       capB;
        logic [7:0] setFlag;
        logic [1:0] toggled;
        logic [4:0] cmdReq;
        logic       cmdWrite;
        logic       breakRise;
        next_q = q;
        acc = read | write;
        wrOk = write & ~q.waitrequest;
        wd = writedata[7:0];
        cmdReq = 5'h00;
        cmdWrite = 1'b0;

        // Avalon handshake: one wait state, data ready with waitrequest low
        next_q.waitrequest = 1'b1;
        if (acc && q.waitrequest) begin
            next_q.waitrequest = 1'b0;
            next_q.readdata = {24'h000000, readReg(address, q)};
        end

        // Event sampling and conditioning
        next_q.sampleA = {q.sampleA[0], eventA};
        next_q.sampleB = {q.sampleB[0], eventB};
        srcA = pickSource(q.event_input_a_control[CFG_HI:CFG_LO], eventA, q.sampleA[1]);
        srcB = pickSource(q.event_input_b_control[CFG_HI:CFG_LO], eventB, q.sampleB[1]);
        {next_q.condA, next_q.filtCountA} =
            filterStep(q.event_input_a_control[CFG_HI:CFG_LO], srcA, q.condA, q.filtCountA);
        {next_q.condB, next_q.filtCountB} =
            filterStep(q.event_input_b_control[CFG_HI:CFG_LO], srcB, q.condB, q.filtCountB);

        actA = q.event_input_a_control[TRIG_EN_BIT] & isActive(q.event_input_a_control, q.condA);
        actB = q.event_input_b_control[TRIG_EN_BIT] & isActive(q.event_input_b_control, q.condB);
        next_q.activeA = actA;
        next_q.activeB = actB;
        edgeA = actA & ~q.activeA;
        edgeB = actB & ~q.activeB;
        // fault always, capture when action set
        capA = edgeA & q.event_input_a_control[ACTION_BIT];
        capB = edgeB & q.event_input_b_control[ACTION_BIT];
        next_q.faultA = actA;
        next_q.faultB = actB;
        next_q.captureA = capA;
        next_q.captureB = capB;

        // Flag sources; set wins over clear
        setFlag = 8'h00;
        setFlag[TRIG_A_BIT] = edgeA | capA;
        setFlag[TRIG_B_BIT] = edgeB | capB;
        setFlag[CYCLE_END_BIT] = cycleEnd;
        if (wrOk && address == INTERRUPT_FLAG_IDX) begin
            next_q.intFlag = q.intFlag & ~wd;
        end
        next_q.intFlag = (next_q.intFlag | setFlag) & FLAG_MASK;

        // Output activity detection
        next_q.waveformPrev = {waveformOutputB, waveformOutputA};
        toggled = q.waveformPrev ^ {waveformOutputB, waveformOutputA};
        if (wrOk && address == SYNC_STATUS_IDX) begin
            next_q.activity = q.activity & ~wd[ACT_B_BIT:ACT_A_BIT];
        end
        next_q.activity = next_q.activity | toggled;

        // Plain register writes
        if (wrOk) begin
            case (address)
                EVENT_INPUT_A_CTRL_IDX: next_q.event_input_a_control = wd & 8'hd5;
                EVENT_INPUT_B_CTRL_IDX: next_q.event_input_b_control = wd & 8'hd5;
                // trigger enables bits 3 and 2
                INTERRUPT_ENABLE_IDX:   next_q.intEnable = wd & FLAG_MASK;
                CONTROL_REG_C_IDX:      next_q.autoUpdate = wd[AUTO_UPDATE_BIT];
                DEBUG_RUN_CONTROL_IDX:  next_q.debugRun = wd[DEBUG_RUN_BIT];
                COMMAND_STROBE_REG_IDX: begin
                    cmdReq = wd[4:0] & CMD_STROBE_MASK[4:0];
                    cmdWrite = |cmdReq;
                end
                COMPARE_B_CLEAR_HI_IDX: begin
                    cmdReq = q.autoUpdate ? CYCLE_END_LOAD_CMD[4:0] : 5'h00;
                    cmdWrite = q.autoUpdate;
                end
                default: ;
            endcase
        end

        // Command synchronisation
        next_q.commandIssue = 5'h00;
        if (q.cmdCount != 4'h0) begin
            next_q.cmdCount = q.cmdCount - 4'h1;
            if (q.cmdCount == 4'h1) begin
                next_q.commandIssue = q.cmdPending;
            end
        end else if (cmdWrite) begin
            next_q.cmdCount = SYNC_LOAD;
            next_q.cmdPending = cmdReq;
        end

        // Enable synchronisation
        breakRise = debugBreak & ~q.breakPrev;
        next_q.breakPrev = debugBreak;
        case (q.enState)
            EN_IDLE: begin
                if (wrOk && address == CONTROL_REG_A_IDX) begin
                    next_q.enable = wd[ENABLE_BIT];
                    next_q.enTarget = wd[ENABLE_BIT];
                    next_q.enCount = SYNC_LOAD;
                    next_q.enState = EN_SYNC;
                end else if (wrOk && address == COMMAND_STROBE_REG_IDX
                             && wd[DISABLE_EOC_BIT]) begin
                    next_q.enState = EN_WAIT_EOC;
                end else if (breakRise && !q.debugRun) begin
                    next_q.enTarget = 1'b0;
                    next_q.enCount = SYNC_LOAD;
                    next_q.enState = EN_SYNC;
                end
            end
            EN_SYNC: begin
                next_q.enCount = q.enCount - 4'h1;
                if (q.enCount == 4'h1) begin
                    next_q.timerEnable = q.enTarget;
                    next_q.enState = EN_IDLE;
                end
            end
            EN_WAIT_EOC: begin
                if (cycleEnd) begin
                    next_q.enable = 1'b0;
                    next_q.timerEnable = 1'b0;
                    next_q.enState = EN_IDLE;
                end
            end
            default: next_q.enState = EN_IDLE;
        endcase

        next_q.irq = |(next_q.intFlag & q.intEnable);
    end

    // State register
    always_ff @(posedge clock) begin
        if (reset) begin
            q <= '0;
            q.waitrequest <= 1'b1;
            q.enState <= EN_IDLE;
            q.event_input_a_control <= RESET_VALUE;
            q.event_input_b_control <= RESET_VALUE;
            q.intEnable <= RESET_VALUE;
            q.intFlag <= RESET_VALUE;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flops
    assign readdata = q.readdata;
    assign waitrequest = q.waitrequest;
    assign faultA = q.faultA;
    assign faultB = q.faultB;
    assign captureA = q.captureA;
    assign captureB = q.captureB;
    assign commandIssue = q.commandIssue;
    assign timerEnable = q.timerEnable;
    assign irq = q.irq;
endmodule : pwm_timer_event_irq_status

// ### tb/pwm_event_sva.sv
// Purpose: port checks for event, flag and command timing
// Assumes: bus writes land at the edge where waitrequest is low
// Notes:   event control and interrupt enable registers are shadowed from bus writes
`timescale 1ns/1ps
module pwm_event_sva
    import pwm_event_pkg::*;
#(
    parameter int SYNC_CYCLES = 4
) (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [4:0]  address,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    input wire logic        eventA,
    input wire logic        cycleEnd,
    input wire logic        faultA,
    input wire logic        faultB,
    input wire logic        captureA,
    input wire logic [4:0]  commandIssue,
    input wire logic        irq
);
    localparam int CMD_MAX = SYNC_CYCLES + 4;
    logic [7:0] control_reg_a;
    logic [7:0] ctrlB;
    logic [7:0] intEn;
    logic       armA;
    logic       cmdBusy;
    // Command in flight, later strobes are ignored
    always_ff @(posedge clock) begin
        if (reset) begin
            cmdBusy <= 1'b0;
        end else if (commandIssue != 5'h00) begin
            cmdBusy <= 1'b0;
        end else if (write && !waitrequest && address == COMMAND_STROBE_REG_IDX
                     && writedata[4:0] != 5'h00) begin
            cmdBusy <= 1'b1;
        end
    end
    // Shadow copies of written controls
    always_ff @(posedge clock) begin
        if (reset) begin
            control_reg_a <= 8'h00;
            ctrlB <= 8'h00;
            intEn <= 8'h00;
        end else if (write && !waitrequest) begin
            if (address == EVENT_INPUT_A_CTRL_IDX) control_reg_a <= writedata[7:0];
            if (address == EVENT_INPUT_B_CTRL_IDX) ctrlB <= writedata[7:0];
            if (address == INTERRUPT_ENABLE_IDX) intEn <= writedata[7:0];
        end
    end
    // Event A enabled on rising level
    assign armA = control_reg_a[EDGE_BIT] && control_reg_a[TRIG_EN_BIT];
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    property p_none;
        $rose(eventA) && armA && control_reg_a[7:6] == CFG_NEITHER ##1 eventA [*5] |-> faultA;
    endproperty
    property p_filt_hold;
        $rose(eventA) && armA && control_reg_a[7:6] == CFG_FILTER |=> !faultA [*5];
    endproperty
    property p_filt_pass;
        $rose(eventA) && armA && control_reg_a[7:6] == CFG_FILTER ##1 eventA [*8] |-> faultA;
    endproperty
    property p_trig_off;
        (!ctrlB[TRIG_EN_BIT]) [*6] |-> !faultB;
    endproperty
    property p_capture;
        captureA |-> control_reg_a[ACTION_BIT] ##1 !captureA;
    endproperty
    property p_irq_set;
        cycleEnd && intEn[CYCLE_END_BIT] |-> ##[1:3] irq;
    endproperty
    property p_irq_quiet;
        (intEn == 8'h00) [*4] |-> !irq;
    endproperty
    property p_cmd;
        !cmdBusy && write && !waitrequest && address == COMMAND_STROBE_REG_IDX
            && writedata[4:0] != 5'h00
            |-> ##[1:CMD_MAX] commandIssue != 5'h00;
    endproperty
    a_none: assert property (p_none) else $error("plain fault late");
    a_filt_hold: assert property (p_filt_hold) else $error("filter too early");
    a_filt_pass: assert property (p_filt_pass) else $error("filter too late");
    a_trig_off: assert property (p_trig_off) else $error("fault while off");
    a_capture: assert property (p_capture) else $error("bad capture");
    a_irq_set: assert property (p_irq_set) else $error("no cycle irq");
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq unmasked");
    a_cmd: assert property (p_cmd) else $error("command lost");
    c_capture: cover property (captureA);
    c_cmd: cover property (commandIssue != 5'h00);
    c_irq: cover property (irq);
endmodule : pwm_event_sva

bind pwm_timer_event_irq_status pwm_event_sva #(.SYNC_CYCLES(SYNC_CYCLES)) pwm_event_sva_i (.*);

// ### tb/timer_core_model.sv
// Purpose: timer core seen by the block: cycle ends, outputs, commands
// Assumes: runs only while the synchronised enable is high
// Notes:   restart command clears the cycle counter
`timescale 1ns/1ps
module timer_core_model #(
    parameter int PERIOD = 16
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       timerEnable,
    input  wire logic [4:0] commandIssue,
    output logic            cycleEnd,
    output logic            waveformOutputA,
    output logic            waveformOutputB,
    output logic [7:0]      nCommands
);
    logic [7:0] count;
    // Cycle counter and end pulse
    always_ff @(posedge clock) begin
        cycleEnd <= 1'b0;
        if (reset || !timerEnable || commandIssue[2]) begin
            count <= 8'h00;
        end else begin
            count <= (count == 8'(PERIOD - 1)) ? 8'h00 : count + 8'h01;
            cycleEnd <= count == 8'(PERIOD - 1);
        end
    end
    // Outputs toggle mid-cycle and at cycle end
    always_ff @(posedge clock) begin
        if (reset) begin
            waveformOutputA <= 1'b0;
            waveformOutputB <= 1'b0;
        end else if (timerEnable) begin
            if (count == 8'(PERIOD / 2)) waveformOutputA <= !waveformOutputA;
            if (cycleEnd) waveformOutputB <= !waveformOutputB;
        end
    end
    // Commands delivered
    always_ff @(posedge clock) begin
        if (reset) nCommands <= 8'h00;
        else if (commandIssue != 5'h00) nCommands <= nCommands + 8'h01;
    end
endmodule : timer_core_model

// ### tb/tb_pwm_timer_event_irq_status.sv
// Purpose: register-level test of event, flag and status behaviour
// Assumes: one wait state per access, sync latency set to 8
// Notes:   timer core model supplies cycle ends and outputs
`timescale 1ns/1ps
module tb_pwm_timer_event_irq_status;
    logic        clock;
    logic        reset;
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        eventA;
    logic        eventB;
    logic        debugBreak;
    logic        cycleEnd;
    logic        waveformOutputA;
    logic        waveformOutputB;
    logic        faultA;
    logic        faultB;
    logic        captureA;
    logic        captureB;
    logic [4:0]  commandIssue;
    logic        timerEnable;
    logic        irq;
    logic [7:0]  nCommands;
    int          nErrors = 0;
    int          testsRun = 0;
    int          ch;
    int          cfg;

    pwm_timer_event_irq_status #(.SYNC_CYCLES(8)) pwm_timer_event_irq_status_i (.*);
    timer_core_model #(.PERIOD(16)) timer_core_model_i (.*);

    // Clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = !clock;
    end

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One bus access, held until waitrequest low
    task automatic acc(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        int i;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, d};
        // Request stands until the edge that sees waitrequest low
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (waitrequest === 1'b0) break;
        end
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (i == 20) begin
            nErrors++;
            end_of_test();
        end
    endtask : acc

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string name);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(name, e, q);
    endtask : rd

    // Set an event level and let it settle
    task automatic ev(input int c, input logic lvl);
        @(posedge clock);
        if (c == 0) eventA <= lvl;
        else eventB <= lvl;
        repeat (12) @(posedge clock);
    endtask : ev

    task automatic wait_ready();
        logic [7:0] q;
        int i;
        for (i = 0; i < 20; i++) begin
            acc(1'b0, 5'h0e, 8'h00, q);
            if (q[1:0] === 2'b11) break;
        end
        if (i == 20) begin
            chk("ready", 8'h03, q);
            end_of_test();
        end
    endtask : wait_ready

    // Main sequence
    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0;
        eventA = 1'b0;
        eventB = 1'b0;
        debugBreak = 1'b0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        rd(5'h08, 8'h00, "ctrl a");
        rd(5'h09, 8'h00, "ctrl b");
        rd(5'h0c, 8'h00, "int enable");
        rd(5'h0d, 8'h00, "flags");
        rd(5'h0e, 8'h03, "status");
        wr(5'h05, 8'hff);
        rd(5'h05, 8'h00, "unmapped");
        // Each channel through each conditioning mode
        wr(5'h0c, 8'h0c);
        for (ch = 0; ch < 2; ch++) begin
            for (cfg = 0; cfg < 3; cfg++) begin
                wr(5'(8 + ch), {cfg[1:0], 6'h15});
                ev(ch, 1'b1);
                rd(5'h0d, (ch == 1) ? 8'h08 : 8'h04, "trig flag");
                chk("irq", 8'h01, {7'h00, irq});
                ev(ch, 1'b0);
                wr(5'h0d, 8'h0d);
                rd(5'h0d, 8'h00, "flag clear");
            end
        end
        // Disabled triggers, then a falling edge
        wr(5'h08, 8'h14);
        wr(5'h09, 8'h14);
        ev(0, 1'b1);
        ev(1, 1'b1);
        rd(5'h0d, 8'h00, "trig off");
        wr(5'h08, 8'h05);
        wr(5'h0d, 8'h0d);
        ev(0, 1'b0);
        rd(5'h0d, 8'h04, "fall flag");
        ev(1, 1'b0);
        wr(5'h08, 8'h00);
        wr(5'h0c, 8'h00);
        wr(5'h0d, 8'h0d);
        // Timer run: cycle end flag and activity
        wr(5'h00, 8'h01);
        rd(5'h0e, 8'h02, "enable sync");
        wait_ready();
        repeat (40) @(posedge clock);
        rd(5'h0d, 8'h01, "cycle flag");
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(5'h0c, 8'h01);
        repeat (3) @(posedge clock);
        chk("irq", 8'h01, {7'h00, irq});
        rd(5'h0e, 8'hc3, "activity");
        wr(5'h04, 8'h80);
        wait_ready();
        repeat (4) @(posedge clock);
        chk("timer off", 8'h00, {7'h00, timerEnable});
        wr(5'h0e, 8'hc0);
        rd(5'h0e, 8'h03, "activity clear");
        wr(5'h0d, 8'h0d);
        rd(5'h0d, 8'h00, "flags");
        chk("irq low", 8'h00, {7'h00, irq});
        // Every strobe, with a second one ignored while busy
        for (cfg = 0; cfg < 5; cfg++) begin
            wr(5'h04, 8'(1 << cfg));
            rd(5'h0e, 8'h01, "cmd busy");
            wr(5'h04, 8'h02);
            wait_ready();
        end
        wr(5'h02, 8'h02);
        wr(5'h1f, 8'h00);
        rd(5'h0e, 8'h01, "auto update busy");
        wait_ready();
        chk("commands", 8'h06, nCommands);
        // Debug break with debug run off stops the timer
        wr(5'h00, 8'h01);
        wait_ready();
        chk("timer on", 8'h01, {7'h00, timerEnable});
        @(posedge clock);
        debugBreak <= 1'b1;
        repeat (2) @(posedge clock);
        wait_ready();
        chk("break off", 8'h00, {7'h00, timerEnable});
        debugBreak <= 1'b0;
        end_of_test();
    end
endmodule : tb_pwm_timer_event_irq_status
